// File: hw/dpp_top.sv
// Debug probe power/config block: config register, sleep timer, UART gating, LED, clock out.
// Assumes a plain register port on the system clock; pins from outside are synchronised.
// Functional notes
// - Serial pins toward the target stay undriven until terminal DTR is asserted.
// - Status LED lights briefly at power-up, is off normally, flashes during link activity.
// - The forwarded clock is 8 MHz at a 3.3V target and 16 MHz at a 5.0V target.
// - With extended-off cleared and no USB enumeration within five seconds, enter deep sleep.
// - In deep sleep the clock out, serial port and program/debug link are all disabled.
// - With the low-power bit cleared the forwarded clock runs at 1 MHz, else at default.
// - In low-power mode USB and the serial port keep working.
// - With the guard bit set, protected configuration writes to the target are blocked.
// - The config register sits at offset 0x0120 and resets to 0xFF.
// - At reset value the clock, serial port, debugging and unprotected programming work; protected configuration writes are blocked.
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ps
module dpp_top
#(
  parameter int unsigned ENUM_TIMEOUT = dpp_pkg::ENUM_TIMEOUT_CYC, // Enumeration wait
  parameter int unsigned LED_BOOT = dpp_pkg::LED_BOOT_CYC, // Power-up LED time
  parameter int unsigned LED_FLASH = dpp_pkg::LED_FLASH_CYC // Activity blink half-period
)
(
  input wire logic sys_clk_in, // 25 MHz clock
  input wire logic reset_in, // Synchronous reset, high
  input wire logic [dpp_pkg::ADDR_W-1:0] reg_addr_in, // Register address
  input wire logic [dpp_pkg::DATA_W-1:0] reg_wdata_in, // Write data
  input wire logic reg_wr_in, // Write strobe
  input wire logic reg_rd_in, // Read strobe
  output logic [dpp_pkg::DATA_W-1:0] reg_rdata_out, // Read data, cycle after strobe
  input wire logic usb_enum_ok_in, // USB enumerated (pin)
  input wire logic dtr_in, // Terminal DTR (pin)
  input wire logic target_high_v_in, // Target at 5.0V (pin)
  input wire logic host_uart_tx_in, // Data from host toward target
  output logic host_uart_rx_out, // Data from target toward host
  output logic uart_tx_out, // Serial pin toward target
  output logic uart_tx_oe_out, // Output enable of the serial pin
  input wire logic uart_rx_in, // Serial pin from target
  input wire logic link_req_in, // Host program/debug request
  input wire logic link_prot_in, // Request writes protected config
  output logic link_go_out, // Request passed to the link
  output logic link_blocked_out, // Request refused
  output logic clk_fwd_out, // Forwarded clock
  output logic led_out, // Status LED, high lights
  output logic sleep_out // Deep sleep
);
  import dpp_pkg::*;
  // Synchroniser stages for pins
  logic [3:0] sync1_q, sync2_q;
  logic enum_s, dtr_s, highv_s, urx_s;
  // Register and state
  logic [2:0] cfg_q, cfg_d;
  logic [DATA_W-1:0] rdata_q, rdata_d;
  dpp_state_t state_q, state_d;
  logic [TMR_W-1:0] tmr_q, tmr_d;
  logic [TMR_W-1:0] led_tmr_q, led_tmr_d;
  logic led_q, led_d;
  logic active_q, active_d;
  logic [TMR_W-1:0] act_tmr_q, act_tmr_d;
  logic utx_q, utx_d, uoe_q, uoe_d, urx_q, urx_d;
  logic go_q, go_d, blk_q, blk_d;
  logic sleep_q, sleep_d;
  logic [PHASE_W-1:0] inc;
  logic clk_en;
  logic usable;

  // Two-flop synchronisers on the external pins
  always_ff @(posedge sys_clk_in)
  begin
    if (reset_in)
    begin
      sync1_q <= 4'h0;
      sync2_q <= 4'h0;
    end
    else
    begin
      sync1_q <= {uart_rx_in, target_high_v_in, dtr_in, usb_enum_ok_in};
      sync2_q <= sync1_q;
    end
  end
  assign enum_s = sync2_q[0];
  assign dtr_s = sync2_q[1];
  assign highv_s = sync2_q[2];
  assign urx_s = sync2_q[3];

  // Register port: write and read-back
  always_comb
  begin
    cfg_d = cfg_q;
    rdata_d = 8'h00;
    if (reg_wr_in && reg_addr_in == PFE_OFFSET)
    begin
      cfg_d = reg_wdata_in[2:0]; // Upper bits dropped
    end
    if (reg_rd_in)
    begin
      if (reg_addr_in == PFE_OFFSET)
      begin
        rdata_d = PFE_RSVD_MASK | {5'h00, cfg_q};
      end
      else if (reg_addr_in == STATUS_OFFSET)
      begin
        rdata_d = 8'h00;
        rdata_d[ST_SLEEP_BIT] = sleep_q;
        rdata_d[ST_SLOW_BIT] = ~cfg_q[PFE_SLOW_CLOCK_N_BIT];
        rdata_d[ST_UART_BIT] = uoe_q;
        rdata_d[ST_HIGHV_BIT] = highv_s;
      end
    end
  end

  // Power state: boot window, run, deep sleep
  always_comb
  begin
    state_d = state_q;
    tmr_d = tmr_q;
    sleep_d = sleep_q;
    unique case (state_q)
      DPP_BOOT:
      begin
        tmr_d = tmr_q + 28'h0000001;
        if (enum_s)
        begin
          state_d = DPP_RUN;
        end
        else if (tmr_q >= TMR_W'(ENUM_TIMEOUT - 1))
        begin
          // Late enumeration only tolerated when extended-off is set
          if (!cfg_q[PFE_EXT_OFF_BIT])
          begin
            state_d = DPP_SLEEP;
            sleep_d = 1'b1;
          end
          else
          begin
            state_d = DPP_RUN;
          end
        end
      end
      DPP_RUN:
      begin
        state_d = DPP_RUN;
      end
      DPP_SLEEP:
      begin
        // Deep sleep is left only by power cycling
        state_d = DPP_SLEEP;
      end
      default:
      begin
        state_d = DPP_BOOT;
      end
    endcase
  end

  // Everything usable unless asleep
  assign usable = !sleep_q;
  // Clock select: 1 MHz when slow, else voltage dependent
  assign inc = !cfg_q[PFE_SLOW_CLOCK_N_BIT] ? INC_1M :
               (highv_s ? INC_16M : INC_8M);
  assign clk_en = usable;

  // Serial gating and program/debug link filter
  always_comb
  begin
    // DTR and deep sleep gate; low-power mode does not touch this path
    uoe_d = usable && dtr_s;
    utx_d = uoe_d ? host_uart_tx_in : 1'b0;
    urx_d = uoe_d ? urx_s : 1'b1;
    go_d = 1'b0;
    blk_d = 1'b0;
    if (link_req_in && usable)
    begin
      if (link_prot_in && cfg_q[PFE_GUARD_BIT])
      begin
        blk_d = 1'b1;
      end
      else
      begin
        go_d = 1'b1;
      end
    end
    else if (link_req_in)
    begin
      blk_d = 1'b1;
    end
  end

  // Status LED: boot flash, off, blink while link busy
  always_comb
  begin
    led_tmr_d = led_tmr_q;
    led_d = 1'b0;
    active_d = active_q;
    act_tmr_d = act_tmr_q;
    if (led_tmr_q < TMR_W'(LED_BOOT))
    begin
      led_tmr_d = led_tmr_q + 28'h0000001;
      led_d = 1'b1;
    end
    // Activity is stretched so short requests still show
    if (go_q)
    begin
      active_d = 1'b1;
      act_tmr_d = '0;
    end
    else if (active_q)
    begin
      act_tmr_d = act_tmr_q + 28'h0000001;
      if (act_tmr_q >= TMR_W'(4 * LED_FLASH - 1))
      begin
        active_d = 1'b0;
      end
    end
    if (active_q && led_tmr_q >= TMR_W'(LED_BOOT))
    begin
      led_d = (act_tmr_q / TMR_W'(LED_FLASH)) % 2 == 0;
    end
  end

  // State registers
  always_ff @(posedge sys_clk_in)
  begin
    if (reset_in)
    begin
      cfg_q <= PFE_RESET[2:0];
      rdata_q <= 8'h00;
      state_q <= DPP_BOOT;
      tmr_q <= '0;
      sleep_q <= 1'b0;
      uoe_q <= 1'b0;
      utx_q <= 1'b0;
      urx_q <= 1'b1;
      go_q <= 1'b0;
      blk_q <= 1'b0;
      led_tmr_q <= '0;
      led_q <= 1'b0;
      active_q <= 1'b0;
      act_tmr_q <= '0;
    end
    else
    begin
      cfg_q <= cfg_d;
      rdata_q <= rdata_d;
      state_q <= state_d;
      tmr_q <= tmr_d;
      sleep_q <= sleep_d;
      uoe_q <= uoe_d;
      utx_q <= utx_d;
      urx_q <= urx_d;
      go_q <= go_d;
      blk_q <= blk_d;
      led_tmr_q <= led_tmr_d;
      led_q <= led_d;
      active_q <= active_d;
      act_tmr_q <= act_tmr_d;
    end
  end

  // Forwarded clock
  dpp_clk_fwd u_clk_fwd
  (
    .sys_clk_in(sys_clk_in),
    .reset_in(reset_in),
    .enable_in(clk_en),
    .inc_in(inc),
    .clk_out(clk_fwd_out)
  );

  assign reg_rdata_out = rdata_q;
  assign uart_tx_out = utx_q;
  assign uart_tx_oe_out = uoe_q;
  assign host_uart_rx_out = urx_q;
  assign link_go_out = go_q;
  assign link_blocked_out = blk_q;
  assign led_out = led_q;
  assign sleep_out = sleep_q;
endmodule // dpp_top

// File: common/dpp_pkg.sv
// Package for the debug probe power/config block: register map, reset values, timing.
// Assumes a single 25 MHz system clock and a synchronous active-high reset.
package dpp_pkg;
  localparam int unsigned CLK_HZ = 25000000;
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 8;
  // Register map
  localparam logic [15:0] PFE_OFFSET = 16'h0120;
  localparam logic [7:0] PFE_RESET = 8'hFF;
  localparam logic [7:0] PFE_RSVD_MASK = 8'hF8;
  localparam int unsigned PFE_EXT_OFF_BIT = 2;
  localparam int unsigned PFE_SLOW_CLOCK_N_BIT = 1;
  localparam int unsigned PFE_GUARD_BIT = 0;
  // Status register of the block's own state
  localparam logic [15:0] STATUS_OFFSET = 16'h0124;
  localparam int unsigned ST_SLEEP_BIT = 0;
  localparam int unsigned ST_SLOW_BIT = 1;
  localparam int unsigned ST_UART_BIT = 2;
  localparam int unsigned ST_HIGHV_BIT = 3;
  // Timing
  localparam int unsigned ENUM_TIMEOUT_S = 5;
  localparam int unsigned ENUM_TIMEOUT_CYC = ENUM_TIMEOUT_S * CLK_HZ;
  localparam int unsigned LED_BOOT_MS = 200;
  localparam int unsigned LED_BOOT_CYC = LED_BOOT_MS * (CLK_HZ / 1000);
  localparam int unsigned LED_FLASH_MS = 50;
  localparam int unsigned LED_FLASH_CYC = LED_FLASH_MS * (CLK_HZ / 1000);
  // Forwarded clock frequencies
  localparam int unsigned FAST_HI_HZ = 16000000;
  localparam int unsigned FAST_LO_HZ = 8000000;
  localparam int unsigned SLOW_HZ = 1000000;
  localparam int unsigned PHASE_W = 24;
  // Phase-accumulator increments: inc = f * 2^PHASE_W / CLK_HZ
  localparam logic [23:0] INC_16M = 24'(64'(FAST_HI_HZ) * 64'h1000000 / 64'(CLK_HZ));
  localparam logic [23:0] INC_8M = 24'(64'(FAST_LO_HZ) * 64'h1000000 / 64'(CLK_HZ));
  localparam logic [23:0] INC_1M = 24'(64'(SLOW_HZ) * 64'h1000000 / 64'(CLK_HZ));
  localparam int unsigned TMR_W = 28;
  typedef enum logic [1:0] {
    DPP_BOOT = 2'b00,
    DPP_RUN = 2'b01,
    DPP_SLEEP = 2'b10
  } dpp_state_t;
endpackage

// File: hw/dpp_clk_fwd.sv
// Forwarded clock generator: phase accumulator, one output pulse per forwarded period.
// Assumes the increment is chosen by the caller; output is a registered pulse train.
`timescale 1ns/1ps
module dpp_clk_fwd
(
  input wire logic sys_clk_in, // System clock
  input wire logic reset_in, // Synchronous reset
  input wire logic enable_in, // Run the clock when high
  input wire logic [dpp_pkg::PHASE_W-1:0] inc_in, // Phase increment
  output logic clk_out // Forwarded clock pulse, one cycle high per wrap
);
  import dpp_pkg::*;
  logic [PHASE_W-1:0] phase_q, phase_d;
  logic clk_q, clk_d;
  logic [PHASE_W:0] sum;
  // Sum with carry; a phase MSB cannot show rates above half the system clock
  assign sum = {1'b0, phase_q} + {1'b0, inc_in};
  // Next phase; held at zero when stopped so restart is glitch free
  always_comb
  begin
    phase_d = '0;
    clk_d = 1'b0;
    if (enable_in)
    begin
      phase_d = sum[PHASE_W-1:0];
      clk_d = sum[PHASE_W]; // One pulse per wrap
    end
  end
  // Registers
  always_ff @(posedge sys_clk_in)
  begin
    if (reset_in)
    begin
      phase_q <= '0;
      clk_q <= 1'b0;
    end
    else
    begin
      phase_q <= phase_d;
      clk_q <= clk_d;
    end
  end
  assign clk_out = clk_q;
endmodule // dpp_clk_fwd

// File: dv/dpp_chk_properties.sv
// Port checker of the probe config block.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module dpp_chk
(
  input wire logic sys_clk_in, // Clock
  input wire logic reset_in, // Reset
  input wire logic reg_rd_in, // Read strobe
  input wire logic [dpp_pkg::ADDR_W-1:0] reg_addr_in, // Address
  input wire logic [dpp_pkg::DATA_W-1:0] reg_rdata_out, // Read data
  input wire logic dtr_in, // DTR
  input wire logic uart_tx_oe_out, // Pin enable
  input wire logic link_req_in, // Request
  input wire logic link_prot_in, // Protected
  input wire logic link_go_out, // Passed
  input wire logic link_blocked_out, // Refused
  input wire logic clk_fwd_out, // Clock out
  input wire logic sleep_out // Sleep
);
  import dpp_pkg::*;
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (reset_in);
  // Register read-back, pin, sleep and link relations
  rsvd_ones_a:
    assert property (reg_rd_in && reg_addr_in == PFE_OFFSET |=> reg_rdata_out[7:3] == 5'h1F)
    else $error("unused bits not ones");
  pin_dtr_a:
    assert property ($rose(uart_tx_oe_out) |-> $past(dtr_in, 3)) else $error("pin driven early");
  pin_drop_a:
    assert property (!dtr_in [*4] |-> !uart_tx_oe_out) else $error("pin driven without dtr");
  sleep_pin_a:
    assert property (sleep_out |=> !uart_tx_oe_out) else $error("pin driven in sleep");
  sleep_clk_a:
    assert property (sleep_out [*2] |-> !clk_fwd_out) else $error("clock runs in sleep");
  sleep_hold_a:
    assert property (sleep_out |=> sleep_out) else $error("sleep left");
  sleep_link_a:
    assert property (sleep_out && link_req_in |=> link_blocked_out) else $error("link in sleep");
  free_pass_a:
    assert property (link_req_in && !link_prot_in && !sleep_out |=> link_go_out)
    else $error("plain request refused");
  one_answer_a:
    assert property (link_req_in |=> link_go_out != link_blocked_out) else $error("bad answer");
endmodule // dpp_chk

// File: dv/dpp_target_model.sv
// Target side model on the serial pins.
// Assumes the bench sets the level the target sends; no pull on the pin.
`timescale 1ns/1ps
module dpp_target_model
(
  input wire logic sys_clk_in, // Clock
  input wire logic pin_in, // Probe pin data
  input wire logic pin_oe_in, // Probe pin enable
  input wire logic tx_level_in, // Level the target sends
  output logic rx_pin_out, // Target output toward probe
  output logic line_out // Level the target sees
);
  logic last_q;
  // Released pin toggles, so a held stale level cannot pass
  always_ff @(posedge sys_clk_in)
    last_q <= line_out;
  assign line_out = pin_oe_in ? pin_in : ~last_q;
  assign rx_pin_out = tx_level_in;
endmodule // dpp_target_model

// File: dv/tb.sv
// Bench of the probe config block: register, link and clock checks.
// Assumes short timing parameters and the target model on the pins.
`timescale 1ns/1ps
module tb;
  import dpp_pkg::*;
  logic clk = 0, rst = 1, wr = 0, rd = 0, en = 0, dtr = 0, hv = 0, htx = 1, tl = 1;
  logic req = 0, prot = 0, hrx, ptx, poe, prx, go, blk, cko, led, slp, line;
  logic [15:0] addr = 16'h0000;
  logic [7:0] wd = 8'h00, rdat;
  int failures = 0, checked = 0, n;
  dpp_top #(.ENUM_TIMEOUT(200), .LED_BOOT(20), .LED_FLASH(4)) uut (.sys_clk_in(clk),
    .reset_in(rst), .reg_addr_in(addr), .reg_wdata_in(wd), .reg_wr_in(wr), .reg_rd_in(rd),
    .reg_rdata_out(rdat), .usb_enum_ok_in(en), .dtr_in(dtr), .target_high_v_in(hv),
    .host_uart_tx_in(htx), .host_uart_rx_out(hrx), .uart_tx_out(ptx), .uart_tx_oe_out(poe),
    .uart_rx_in(prx), .link_req_in(req), .link_prot_in(prot), .link_go_out(go),
    .link_blocked_out(blk), .clk_fwd_out(cko), .led_out(led), .sleep_out(slp));
  dpp_target_model tgt (.sys_clk_in(clk), .pin_in(ptx), .pin_oe_in(poe), .tx_level_in(tl),
    .rx_pin_out(prx), .line_out(line));
  always #20 clk = ~clk;
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    checked++;
    if (s !== e)
    begin
      failures++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, s, e);
    end
  endtask
  task automatic cyc(input int c);
    repeat (c) @(posedge clk);
  endtask
  task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // Data stands only in the cycle after the strobe
  task automatic rd_reg(input logic [15:0] a, input logic [7:0] e, input logic [7:0] m);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdat & m, e);
  endtask
  task automatic link(input logic p, input logic [7:0] e);
    @(posedge clk);
    req <= 1'b1;
    prot <= p;
    @(posedge clk);
    req <= 1'b0;
    #1 chk({go, blk}, e);
  endtask
  // Forwarded clock pulses over 1000 cycles, one pulse of slack while running
  task automatic clk_cnt(input int e);
    n = 0;
    repeat (1000)
    begin
      @(posedge clk);
      n += int'(cko === 1'b1);
    end
    chk(8'(n == e || (e > 0 && n >= e - 1 && n <= e + 1)), 8'h01);
  endtask
  task automatic complete_run();
    $display("checks %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Hang guard
  initial
  begin
    #4000000;
    failures++;
    complete_run();
  end
  initial
  begin
    cyc(4);
    rst <= 1'b0;
    cyc(3);
    chk(led, 1);
    cyc(25);
    chk(led, 0);
    rd_reg(PFE_OFFSET, 8'hFF, 8'hFF);
    clk_cnt(320);
    hv <= 1'b1;
    cyc(4);
    clk_cnt(640);
    chk(slp, 0);
    wr_reg(PFE_OFFSET, 8'h00);
    rd_reg(PFE_OFFSET, 8'hF8, 8'hFF);
    rd_reg(16'h0200, 8'h00, 8'hFF);
    rd_reg(STATUS_OFFSET, 8'h0A, 8'h0F);
    clk_cnt(40);
    chk({slp, poe}, 0);
    dtr <= 1'b1;
    htx <= 1'b0;
    tl <= 1'b0;
    cyc(5);
    chk({poe, line, hrx}, 8'h04);
    htx <= 1'b1;
    tl <= 1'b1;
    cyc(5);
    chk({line, hrx}, 8'h03);
    link(1, 8'h02);
    wr_reg(PFE_OFFSET, 8'h01);
    link(1, 8'h01);
    link(0, 8'h02);
    n = 0;
    repeat (12)
    begin
      @(posedge clk);
      n += int'(led === 1'b1);
    end
    chk(8'(n > 0 && n < 12), 8'h01);
    dtr <= 1'b0;
    wr_reg(PFE_OFFSET, 8'h07);
    cyc(5);
    chk(poe, 0);
    clk_cnt(640);
    rst <= 1'b1;
    cyc(4);
    rst <= 1'b0;
    wr_reg(PFE_OFFSET, 8'h03);
    en <= 1'b1;
    cyc(300);
    chk(slp, 0);
    en <= 1'b0;
    rst <= 1'b1;
    cyc(4);
    rst <= 1'b0;
    wr_reg(PFE_OFFSET, 8'h03);
    dtr <= 1'b1;
    for (n = 0; n < 300 && slp !== 1'b1; n++)
      @(posedge clk);
    chk(slp, 1);
    if (slp !== 1'b1)
      complete_run();
    cyc(3);
    chk(poe, 0);
    rd_reg(STATUS_OFFSET, 8'h09, 8'h0F);
    clk_cnt(0);
    link(0, 8'h01);
    complete_run();
  end
endmodule // tb
bind dpp_top dpp_chk chk_i (.sys_clk_in(sys_clk_in), .reset_in(reset_in), .reg_rd_in(reg_rd_in),
  .reg_addr_in(reg_addr_in), .reg_rdata_out(reg_rdata_out), .dtr_in(dtr_in),
  .uart_tx_oe_out(uart_tx_oe_out), .link_req_in(link_req_in), .link_prot_in(link_prot_in),
  .link_go_out(link_go_out), .link_blocked_out(link_blocked_out), .clk_fwd_out(clk_fwd_out),
  .sleep_out(sleep_out));
